// file: rtl/evcnt_pkg.sv
// event counter package: register map, field layout, selector encodings
// assumes one 100 MHz clock and an AHB-Lite slave with word-aligned access
package evcnt_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int COUNT_W = 32;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SELECT = 8'h04;
  localparam logic [7:0] ADDR_TERMINAL = 8'h08;
  localparam logic [7:0] ADDR_VALUE = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int SEL_BEGIN_LSB = 0;
  localparam int SEL_BEGIN_EDGE_LSB = 8;
  localparam int SEL_INC_LSB = 16;
  localparam int SEL_INC_EDGE_LSB = 24;
  localparam int SRC_W = 4;
  localparam int EDGE_W = 2;

  localparam logic [31:0] TERMINAL_RESET = 32'h0000_0001;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;

  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;
  localparam int IRQ_W = 2;

  // source encodings of the begin selector; the increment selector uses all but count done
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_ACQ_BEGIN = 4'h1;
  localparam logic [3:0] SRC_ACQ_FINISH = 4'h2;
  localparam logic [3:0] SRC_EXPOSE_BEGIN = 4'h3;
  localparam logic [3:0] SRC_EXPOSE_FINISH = 4'h4;
  localparam logic [3:0] SRC_FRAME_BEGIN = 4'h5;
  localparam logic [3:0] SRC_ACCEPTED_TRIG = 4'h6;
  localparam logic [3:0] SRC_REJECTED_TRIG = 4'h7;
  localparam logic [3:0] SRC_PIN_A = 4'h8;
  localparam logic [3:0] SRC_PIN_B = 4'h9;
  localparam logic [3:0] SRC_PIN_C = 4'hA;
  localparam logic [3:0] SRC_TICK = 4'hB;
  localparam logic [3:0] SRC_TIMER_DONE = 4'hC;
  localparam logic [3:0] SRC_COUNT_DONE = 4'hD;

  localparam logic [1:0] EDGE_UP = 2'h0;
  localparam logic [1:0] EDGE_DOWN = 2'h1;
  localparam logic [1:0] EDGE_EITHER = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_BEGIN,
    ST_COUNTING,
    ST_COMPLETED,
    ST_OVERFLOW
  } counter_state_e;
endpackage

// file: rtl/pin_edge_detect.sv
// synchronises external input pins and produces edge pulses per pin
// assumes pins are asynchronous to clk
module pin_edge_detect #(
  parameter int PINS = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PINS-1:0] pin,
  output logic [PINS-1:0] rise,
  output logic [PINS-1:0] fall
);
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] last;

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
          last[i] <= 1'b0;
        end else begin
          sync_a[i] <= pin[i];
          sync_b[i] <= sync_a[i];
          last[i] <= sync_b[i];
        end
      end
      // one pulse per transition, read only past the second stage
      assign rise[i] = sync_b[i] & ~last[i];
      assign fall[i] = ~sync_b[i] & last[i];
    end
  endgenerate
endmodule

// file: rtl/us_tick_gen.sv
// divides the reference clock into a one-cycle microsecond enable
// assumes the clock rate in the package
module us_tick_gen #(
  parameter int DIV = evcnt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [15:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// file: rtl/event_counter.sv
// general purpose event counter with selectable begin and increment sources
// assumes camera event inputs are one-cycle pulses on REF_CLK and the
// input pins are asynchronous; registers sit on an AHB-Lite slave port
//
// Contract
// - with begin source timer done, counting begins on timer_done_event.
// - with begin source count done, counting begins on count_done_event.
// - the begin edge qualifier only matters for input pin begin sources.
// - pin begin sources fire on up, down or either transition as chosen.
// - only the chosen increment source counts; off means no increments.
// - internal camera events add one per occurrence when chosen.
// - a chosen input pin counts transitions matching the edge qualifier.
// - the microsecond tick source adds one per microsecond.
// - the timer done source adds one per timer_done_event.
// - the increment qualifier picks up, down or either transitions.
// - the increment qualifier is ignored for non-pin sources.
// - a started counter counts up from zero to the terminal count.
// - counter_state reports idle, wait, counting, completed or overflow.
// - count_done_event is raised when the terminal count is reached.
// - the counter runs only while enabled; configure it while disabled.
module event_counter #(
  parameter int W = evcnt_pkg::COUNT_W
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic ACQ_BEGIN_EVENT,
  input wire logic ACQ_FINISH_EVENT,
  input wire logic EXPOSE_BEGIN_EVENT,
  input wire logic EXPOSE_FINISH_EVENT,
  input wire logic FRAME_BEGIN_EVENT,
  input wire logic ACCEPTED_FRAME_TRIG,
  input wire logic REJECTED_TRIG_EVENT,
  input wire logic TIMER_DONE_EVENT,
  input wire logic INPUT_PIN_A,
  input wire logic INPUT_PIN_B,
  input wire logic INPUT_PIN_C,
  output logic COUNT_DONE_EVENT,
  output logic [W-1:0] COUNT_VALUE,
  output logic IRQ
);
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic tick;

  pin_edge_detect #(.PINS(3)) u_pins (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .pin({INPUT_PIN_C, INPUT_PIN_B, INPUT_PIN_A}),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  us_tick_gen u_tick (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .tick(tick)
  );

  // configuration registers, interrupt status and mask, counter state and count
  logic counter_enable_setting;
  logic [3:0] count_begin_select;
  logic [1:0] begin_edge_qualifier;
  logic [3:0] increment_source_select;
  logic [1:0] increment_edge_qualifier;
  logic [W-1:0] terminal_count_setting;
  logic [evcnt_pkg::IRQ_W-1:0] irq_status;
  logic [evcnt_pkg::IRQ_W-1:0] irq_mask;
  evcnt_pkg::counter_state_e counter_state;
  logic [W-1:0] count;

  // AHB-Lite address phase capture
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic take;

  assign take = HSEL & HREADY & HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (HREADY) begin
      ph_valid <= take;
      ph_write <= HWRITE;
      ph_addr <= HADDR[7:0];
    end
  end

  logic wr;
  logic rd_status;
  assign wr = ph_valid & ph_write;
  assign rd_status = take & ~HWRITE &
    (HADDR[7:0] == evcnt_pkg::ADDR_IRQ_STATUS);

  // config writes are accepted any time, but software should only change
  // sources and terminal count while disabled
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      counter_enable_setting <= 1'b0;
      count_begin_select <= evcnt_pkg::SELECT_RESET[3:0];
      begin_edge_qualifier <= evcnt_pkg::EDGE_UP;
      increment_source_select <= evcnt_pkg::SELECT_RESET[3:0];
      increment_edge_qualifier <= evcnt_pkg::EDGE_UP;
      terminal_count_setting <= W'(evcnt_pkg::TERMINAL_RESET);
      irq_mask <= '0;
    end else if (wr) begin
      case (ph_addr)
        evcnt_pkg::ADDR_CTRL: begin
          counter_enable_setting <= HWDATA[evcnt_pkg::CTRL_ENABLE_BIT];
        end
        evcnt_pkg::ADDR_SELECT: begin
          count_begin_select <=
            HWDATA[evcnt_pkg::SEL_BEGIN_LSB +: evcnt_pkg::SRC_W];
          begin_edge_qualifier <=
            HWDATA[evcnt_pkg::SEL_BEGIN_EDGE_LSB +: evcnt_pkg::EDGE_W];
          increment_source_select <=
            HWDATA[evcnt_pkg::SEL_INC_LSB +: evcnt_pkg::SRC_W];
          increment_edge_qualifier <=
            HWDATA[evcnt_pkg::SEL_INC_EDGE_LSB +: evcnt_pkg::EDGE_W];
        end
        evcnt_pkg::ADDR_TERMINAL: begin
          terminal_count_setting <= HWDATA[W-1:0];
        end
        evcnt_pkg::ADDR_IRQ_MASK: begin
          irq_mask <= HWDATA[evcnt_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // shared source decode; edge qualifier applies to pins only
  function automatic logic src_pulse(
    input logic [3:0] sel,
    input logic [1:0] edge_q,
    input logic [7:0] evt,
    input logic [2:0] rise,
    input logic [2:0] fall,
    input logic tk,
    input logic own_done
  );
    logic [2:0] pin_hit;
    logic hit;
    pin_hit = 3'h0;
    hit = 1'b0;
    case (edge_q)
      evcnt_pkg::EDGE_UP: pin_hit = rise;
      evcnt_pkg::EDGE_DOWN: pin_hit = fall;
      evcnt_pkg::EDGE_EITHER: pin_hit = rise | fall;
      default: pin_hit = 3'h0;
    endcase
    case (sel)
      evcnt_pkg::SRC_ACQ_BEGIN: hit = evt[0];
      evcnt_pkg::SRC_ACQ_FINISH: hit = evt[1];
      evcnt_pkg::SRC_EXPOSE_BEGIN: hit = evt[2];
      evcnt_pkg::SRC_EXPOSE_FINISH: hit = evt[3];
      evcnt_pkg::SRC_FRAME_BEGIN: hit = evt[4];
      evcnt_pkg::SRC_ACCEPTED_TRIG: hit = evt[5];
      evcnt_pkg::SRC_REJECTED_TRIG: hit = evt[6];
      evcnt_pkg::SRC_PIN_A: hit = pin_hit[0];
      evcnt_pkg::SRC_PIN_B: hit = pin_hit[1];
      evcnt_pkg::SRC_PIN_C: hit = pin_hit[2];
      evcnt_pkg::SRC_TICK: hit = tk;
      evcnt_pkg::SRC_TIMER_DONE: hit = evt[7];
      evcnt_pkg::SRC_COUNT_DONE: hit = own_done;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [7:0] cam_evt;
  assign cam_evt = {TIMER_DONE_EVENT, REJECTED_TRIG_EVENT,
    ACCEPTED_FRAME_TRIG, FRAME_BEGIN_EVENT, EXPOSE_FINISH_EVENT,
    EXPOSE_BEGIN_EVENT, ACQ_FINISH_EVENT, ACQ_BEGIN_EVENT};

  logic begin_hit;
  logic inc_hit;

  // begin pulse, qualifier used only for pin sources
  assign begin_hit = src_pulse(count_begin_select, begin_edge_qualifier,
    cam_evt, pin_rise, pin_fall, tick, COUNT_DONE_EVENT);
  // own-done is not an increment choice, so it is masked out by passing 0
  assign inc_hit = (increment_source_select != evcnt_pkg::SRC_COUNT_DONE) &
    src_pulse(increment_source_select, increment_edge_qualifier, cam_evt,
    pin_rise, pin_fall, tick, 1'b0);

  logic at_terminal;
  logic at_max;
  assign at_terminal = (W'(count + W'(1)) >= terminal_count_setting);
  assign at_max = (count == {W{1'b1}});

  // counter state machine
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      counter_state <= evcnt_pkg::ST_IDLE;
      count <= '0;
      COUNT_DONE_EVENT <= 1'b0;
    end else begin
      COUNT_DONE_EVENT <= 1'b0;
      if (!counter_enable_setting ||
          count_begin_select == evcnt_pkg::SRC_OFF) begin
        counter_state <= evcnt_pkg::ST_IDLE;
      end else begin
        case (counter_state)
          evcnt_pkg::ST_IDLE: begin
            counter_state <= evcnt_pkg::ST_WAIT_BEGIN;
          end
          evcnt_pkg::ST_WAIT_BEGIN, evcnt_pkg::ST_COMPLETED,
          evcnt_pkg::ST_OVERFLOW: begin
            if (begin_hit) begin
              count <= '0;
              counter_state <= evcnt_pkg::ST_COUNTING;
            end
          end
          evcnt_pkg::ST_COUNTING: begin
            if (inc_hit) begin
              if (at_max) begin
                counter_state <= evcnt_pkg::ST_OVERFLOW;
              end else begin
                count <= count + W'(1);
                if (at_terminal) begin
                  counter_state <= evcnt_pkg::ST_COMPLETED;
                  COUNT_DONE_EVENT <= 1'b1;
                end
              end
            end
          end
          default: counter_state <= evcnt_pkg::ST_IDLE;
        endcase
      end
    end
  end

  assign COUNT_VALUE = count;

  // sticky interrupt bits; a set in the clearing read cycle wins
  logic overflow_evt;
  assign overflow_evt = (counter_state == evcnt_pkg::ST_COUNTING) &
    inc_hit & at_max & counter_enable_setting;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < evcnt_pkg::IRQ_W; i++) begin
        if (rd_status) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (COUNT_DONE_EVENT) begin
        irq_status[evcnt_pkg::IRQ_DONE_BIT] <= 1'b1;
      end
      if (overflow_evt) begin
        irq_status[evcnt_pkg::IRQ_OVERFLOW_BIT] <= 1'b1;
      end
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // read data is registered in the address phase
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h0000_0000;
    end else if (take & ~HWRITE) begin
      case (HADDR[7:0])
        evcnt_pkg::ADDR_CTRL: HRDATA <= {31'h0, counter_enable_setting};
        evcnt_pkg::ADDR_SELECT: HRDATA <= {6'h0, increment_edge_qualifier,
          4'h0, increment_source_select, 6'h0, begin_edge_qualifier, 4'h0,
          count_begin_select};
        evcnt_pkg::ADDR_TERMINAL: HRDATA <= 32'(terminal_count_setting);
        evcnt_pkg::ADDR_VALUE: HRDATA <= 32'(count);
        evcnt_pkg::ADDR_STATE: HRDATA <= {29'h0, counter_state};
        evcnt_pkg::ADDR_IRQ_STATUS: HRDATA <= 32'(irq_status);
        evcnt_pkg::ADDR_IRQ_MASK: HRDATA <= 32'(irq_mask);
        default: HRDATA <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// file: verif/evcnt_chk.sv
// concurrent checks on the event counter ports: bus answer, count steps
// assumes it is bound onto event_counter and sees nothing but its ports
module evcnt_chk #(
  parameter int W = 32
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic COUNT_DONE_EVENT,
  input wire logic [W-1:0] COUNT_VALUE,
  input wire logic IRQ
);
  logic rd_take;
  assign rd_take = HSEL & HREADY & HTRANS[1] & ~HWRITE;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // outputs stay cleared while the reset copy is still synchronising
  sequence s_held;
    (COUNT_VALUE == '0 && !IRQ && !COUNT_DONE_EVENT) [*2];
  endsequence
  sequence s_quiet;
    $stable(COUNT_VALUE) [*3];
  endsequence
  chk_zero_wait: assert property (HREADYOUT)
    else $error("slave inserted a wait state");
  chk_resp_okay: assert property (!HRESP)
    else $error("slave answered with an error response");
  chk_reset_quiet: assert property ($rose(ARST_N) |-> s_held)
    else $error("outputs not cleared after reset");
  chk_done_pulse: assert property (
    COUNT_DONE_EVENT |=> !COUNT_DONE_EVENT)
    else $error("done pulse longer than one cycle");
  chk_done_after_inc: assert property (
    COUNT_DONE_EVENT |-> COUNT_VALUE != '0 &&
    ($past(COUNT_VALUE) != COUNT_VALUE ||
    $past(COUNT_VALUE, 2) != COUNT_VALUE))
    else $error("done pulse without a final increment");
  chk_value_step: assert property (
    $changed(COUNT_VALUE) |-> COUNT_VALUE == '0 ||
    COUNT_VALUE - $past(COUNT_VALUE) == W'(1))
    else $error("count moved by other than one");
  chk_done_quiet: assert property (COUNT_DONE_EVENT |=> s_quiet)
    else $error("count moved after completion");
  chk_read_hold: assert property (
    $changed(HRDATA) |-> $past(rd_take) || $past(rd_take, 2))
    else $error("read data changed without a read");
endmodule

bind event_counter evcnt_chk #(.W(W)) u_chk (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .COUNT_DONE_EVENT(COUNT_DONE_EVENT), .COUNT_VALUE(COUNT_VALUE),
  .IRQ(IRQ)
);

// file: verif/evt_src.sv
// camera event sources and external input pins beside the counter
// assumes events are one-cycle pulses on clk; pins change at any time
module evt_src (
  input wire logic clk,
  output logic [7:0] evt,
  output logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    evt = '0;
    pins = '0;
  end
  // an edge passes between pulses so each one is seen on its own
  task automatic pulse(input int i);
    @(posedge clk);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt[i] <= 1'b0;
  endtask
  // pins are held long enough to clear the synchroniser before the next
  task automatic toggle(input int p);
    @(posedge clk);
    pins[p] <= ~pins[p];
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: verif/event_counter_tb.sv
// self-checking bench for the event counter over AHB-Lite
// assumes evt_src drives the camera events and pins, checker bound in
module event_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, done, irq;
  logic [31:0] haddr, hwdata, hrdata, value;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] evt;
  logic [2:0] pins;
  int fails, tests_run, done_cnt, cyc;
  evt_src src (.clk(clk), .evt(evt), .pins(pins));
  event_counter dut (
    .REF_CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .ACQ_BEGIN_EVENT(evt[0]), .ACQ_FINISH_EVENT(evt[1]),
    .EXPOSE_BEGIN_EVENT(evt[2]), .EXPOSE_FINISH_EVENT(evt[3]),
    .FRAME_BEGIN_EVENT(evt[4]), .ACCEPTED_FRAME_TRIG(evt[5]),
    .REJECTED_TRIG_EVENT(evt[6]), .TIMER_DONE_EVENT(evt[7]),
    .INPUT_PIN_A(pins[0]), .INPUT_PIN_B(pins[1]), .INPUT_PIN_C(pins[2]),
    .COUNT_DONE_EVENT(done), .COUNT_VALUE(value), .IRQ(irq)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1) begin
      done_cnt++;
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic setup(input logic [3:0] bs, input logic [1:0] be,
                       input logic [3:0] is, input logic [1:0] ie,
                       input logic [31:0] term);
    wr(evcnt_pkg::ADDR_CTRL, 32'h0);
    wr(evcnt_pkg::ADDR_SELECT, {6'h0, ie, 4'h0, is, 6'h0, be, 4'h0, bs});
    wr(evcnt_pkg::ADDR_TERMINAL, term);
    wr(evcnt_pkg::ADDR_CTRL, 32'h1);
  endtask
  initial begin
    logic [31:0] q;
    int d0, t0, n;
    {arst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(evcnt_pkg::ADDR_TERMINAL, q);
    chk("terminal reset", evcnt_pkg::TERMINAL_RESET, q);
    rd(evcnt_pkg::ADDR_SELECT, q);
    chk("select reset", evcnt_pkg::SELECT_RESET, q);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, q);
    chk("unmapped read", 32'h0, q);
    setup(4'h0, 2'h0, 4'hB, 2'h0, 32'h1);
    rd(evcnt_pkg::ADDR_STATE, q);
    chk("begin off state", 32'h0, q);
    setup(4'hD, 2'h0, 4'hB, 2'h0, 32'h1);
    rd(evcnt_pkg::ADDR_STATE, q);
    chk("waiting state", 32'h1, q);
    $display("register test finished");
    for (int i = 0; i < 7; i++) begin
      setup(4'hC, 2'h1, 4'(i + 1), 2'h1, 32'h3);
      d0 = done_cnt;
      src.pulse(7);
      rd(evcnt_pkg::ADDR_STATE, q);
      chk("started by timer", 32'h2, q);
      src.pulse(i);
      src.pulse((i + 1) % 7);
      src.pulse(i);
      rd(evcnt_pkg::ADDR_VALUE, q);
      chk("event count", 32'h2, q);
      src.pulse(i);
      repeat (4) @(posedge clk);
      rd(evcnt_pkg::ADDR_STATE, q);
      chk("completed", 32'h3, q);
      chk("done pulses", 32'(d0 + 1), 32'(done_cnt));
    end
    setup(4'h1, 2'h0, 4'h0, 2'h0, 32'h3);
    src.pulse(0);
    for (int i = 0; i < 8; i++) src.pulse(i);
    repeat (250) @(posedge clk);
    rd(evcnt_pkg::ADDR_VALUE, q);
    chk("source off", 32'h0, q);
    $display("internal event test finished");
    for (int p = 0; p < 3; p++) begin
      for (int e = 0; e < 3; e++) begin
        setup(4'(8 + p), 2'(e), 4'(8 + p), 2'(e), 32'hFF);
        repeat (4) src.toggle(p);
        rd(evcnt_pkg::ADDR_VALUE, q);
        chk("pin count", (e == 2) ? 32'h3 : 32'h1, q);
      end
    end
    $display("pin test finished");
    rd(evcnt_pkg::ADDR_IRQ_STATUS, q);
    wr(evcnt_pkg::ADDR_IRQ_MASK, 32'h1);
    setup(4'h1, 2'h1, 4'hB, 2'h1, 32'h3);
    src.pulse(0);
    t0 = cyc;
    n = 0;
    do begin
      rd(evcnt_pkg::ADDR_STATE, q);
      n++;
    end while (q !== 32'h3 && n < 300);
    if (n >= 300) begin
      fails++;
      wrap_up();
    end
    n = cyc - t0;
    chk("tick timing", 32'h1, 32'(n >= 2 * evcnt_pkg::TICK_CYCLES &&
        n <= 3 * evcnt_pkg::TICK_CYCLES + 10));
    chk("irq raised", 32'h1, 32'(irq));
    rd(evcnt_pkg::ADDR_IRQ_STATUS, q);
    chk("status done", 32'h1, q);
    chk("irq cleared", 32'h0, 32'(irq));
    rd(evcnt_pkg::ADDR_IRQ_STATUS, q);
    chk("status cleared", 32'h0, q);
    wr(evcnt_pkg::ADDR_IRQ_MASK, 32'h0);
    setup(4'h2, 2'h0, 4'hC, 2'h0, 32'h2);
    src.pulse(1);
    src.pulse(7);
    src.pulse(7);
    repeat (4) @(posedge clk);
    rd(evcnt_pkg::ADDR_VALUE, q);
    chk("timer increments", 32'h2, q);
    chk("irq masked", 32'h0, 32'(irq));
    rd(evcnt_pkg::ADDR_IRQ_STATUS, q);
    chk("masked status", 32'h1, q);
    $display("tick and interrupt test finished");
    wrap_up();
  end
endmodule
